// [logic/node_cfg_pkg.sv]
package node_cfg_pkg;
	localparam int          ADDR_W           = 8;
	localparam int          DATA_W           = 32;
	localparam logic [7:0]  OFS_IDENT        = 8'h00;
	localparam logic [7:0]  OFS_NODE_CONF    = 8'h04;
	localparam logic [7:0]  OFS_NODE_ID      = 8'h05;
	localparam logic [7:0]  OFS_CLK_MHZ      = 8'h51;
	localparam logic [7:0]  OFS_LINK         = 8'h80;
	// identification word fields
	localparam int          CHIP_LSB         = 24;
	localparam int          REV_LSB          = 8;
	localparam int          VER_LSB          = 0;
	// node configuration fields
	localparam int          LOCK_BIT         = 31;
	localparam int          HDR_BIT          = 0;
	// node identifier / clock fields
	localparam int          NODE_ID_W        = 16;
	localparam int          MHZ_W            = 7;
	localparam logic [6:0]  MHZ_RESET        = 7'h19;
	localparam logic [6:0]  MHZ_MIN          = 7'h05;
	localparam logic [6:0]  MHZ_MAX          = 7'h64;
	// link control fields
	localparam int          RX_ERR_BIT       = 27;
	localparam int          RX_CREDIT_BIT    = 26;
	localparam int          TX_CREDIT_BIT    = 25;
	localparam int          GREET_BIT        = 24;
	localparam int          RX_RESET_BIT     = 23;
	localparam int          GAP_W            = 11;
	localparam int          SYM_GAP_LSB      = 11;
	localparam int          TOK_GAP_LSB      = 0;
	localparam logic [10:0] GAP_RESET        = 11'h001;
endpackage : node_cfg_pkg

// [logic/usb_node_config_regs.sv]
// Functional notes
// RL1: Registers are reached only through node configuration read and write transactions.
// RL2: Offset zero is a read-only identification word with chip code, block revision and version.
// RL3: Writing one to bit 31 of node configuration blocks later updates of configuration and link registers.
// RL4: Once locked, protected writes leave contents unchanged until the next reset clears the lock.
// RL5: Bit 0 selects three-byte headers when zero and one-byte headers when one, reset zero.
// RL6: The node identifier is a writable 16-bit field in bits 15:0, reset zero, stored only.
// RL7: The clock frequency field in bits 6:0 holds megahertz rounded up and resets to 25.
// RL8: A frequency write below 5 or above 100 is discarded and answered with a negative acknowledge.
// RL9: The configuring party programs the frequency at start-up and whenever the oscillator changes.
// RL10: Read-only bit 27 reports receive buffer overflow or an illegally encoded token.
// RL11: Read-only bit 26 shows this end granted credit to the remote end, reset zero.
// RL12: Read-only bit 25 shows this end holds credit to send, reset zero.
// RL13: Writing one to bit 24 clears local transmit credit and sends a greeting token.
// RL14: Writing one to bit 23 resets the receiver so the next symbol starts a token.
// RL15: Bits 21:11 hold the minimum idle clocks between symbols in a token minus one, reset 1.
// RL16: Bits 10:0 hold the minimum idle clocks between tokens minus one, reset 1.
`timescale 1ns/1ns
module usb_node_config_regs
	import node_cfg_pkg::*;
#(
	parameter logic [7:0] CHIP_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] BLOCK_REV = 8'h11, // arbitrary value
	parameter logic [7:0] BLOCK_VER = 8'h22  // arbitrary value
)
(
	input  wire logic              clk,            // 20 MHz system clock
	input  wire logic              sys_rst,        // sync reset, high
	input  wire logic              cfg_req,        // transaction request
	input  wire logic              cfg_write,      // 1 write, 0 read
	input  wire logic [ADDR_W-1:0] cfg_addr,       // register number
	input  wire logic [DATA_W-1:0] cfg_wdata,      // write data
	output logic                   cfg_ack,        // answer pulse
	output logic                   cfg_nack,       // answer was refused
	output logic      [DATA_W-1:0] cfg_rdata,      // read data
	input  wire logic              rx_error_in,    // link receive error
	input  wire logic              rx_credit_in,   // credit issued
	input  wire logic              tx_credit_in,   // credit held
	output logic                   header_length_select, // 1: 1-byte
	output logic [NODE_ID_W-1:0]   node_identifier_field, // stored id
	output logic [MHZ_W-1:0]       clock_megahertz_field, // clk in MHz
	output logic                   send_greeting_strobe,  // pulse
	output logic                   rx_reset_strobe,       // pulse
	output logic [GAP_W-1:0]       symbol_gap_field,      // count - 1
	output logic [GAP_W-1:0]       token_gap_field,       // count - 1
	output logic                   update_lock            // lock state
);

	logic              lock_r;
	logic              hdr_r;
	logic [15:0]       node_id_r;
	logic [6:0]        mhz_r;
	logic [10:0]       sym_gap_r;
	logic [10:0]       tok_gap_r;
	logic              wr;
	logic              mhz_ok;
	logic [DATA_W-1:0] rd_nxt;
	logic              nack_nxt;

	// writes accepted only by config transactions; lock guards all
	assign wr = cfg_req & cfg_write & ~lock_r; // RL1 RL3 RL4
	assign mhz_ok = (cfg_wdata[MHZ_W-1:0] >= MHZ_MIN)
		&& (cfg_wdata[MHZ_W-1:0] <= MHZ_MAX)
		&& (cfg_wdata[DATA_W-1:MHZ_W] == '0); // RL8

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			lock_r <= 1'b0; // RL4
		else if (wr && cfg_addr == OFS_NODE_CONF && cfg_wdata[LOCK_BIT])
			lock_r <= 1'b1; // RL3
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			hdr_r <= 1'b0;
		else if (wr && cfg_addr == OFS_NODE_CONF)
			hdr_r <= cfg_wdata[HDR_BIT]; // RL5
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			node_id_r <= '0;
		else if (wr && cfg_addr == OFS_NODE_ID)
			node_id_r <= cfg_wdata[NODE_ID_W-1:0]; // RL6
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			mhz_r <= MHZ_RESET; // RL7
		else if (wr && cfg_addr == OFS_CLK_MHZ && mhz_ok)
			mhz_r <= cfg_wdata[MHZ_W-1:0]; // RL8
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sym_gap_r <= GAP_RESET;
			tok_gap_r <= GAP_RESET;
		end
		else if (wr && cfg_addr == OFS_LINK)
		begin
			sym_gap_r <= cfg_wdata[SYM_GAP_LSB +: GAP_W]; // RL15
			tok_gap_r <= cfg_wdata[TOK_GAP_LSB +: GAP_W]; // RL16
		end
	end

	// write-only strobes: one-cycle pulses, never read back
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			send_greeting_strobe <= 1'b0;
			rx_reset_strobe      <= 1'b0;
		end
		else
		begin
			send_greeting_strobe <= wr && cfg_addr == OFS_LINK
				&& cfg_wdata[GREET_BIT]; // RL13
			rx_reset_strobe      <= wr && cfg_addr == OFS_LINK
				&& cfg_wdata[RX_RESET_BIT]; // RL14
		end
	end

	always_comb
	begin
		rd_nxt   = '0;
		nack_nxt = 1'b0;
		case (cfg_addr)
			OFS_IDENT:
			begin
				rd_nxt[CHIP_LSB +: 8] = CHIP_CODE; // RL2
				rd_nxt[REV_LSB +: 8]  = BLOCK_REV;
				rd_nxt[VER_LSB +: 8]  = BLOCK_VER;
			end
			OFS_NODE_CONF:
			begin
				rd_nxt[LOCK_BIT] = lock_r;
				rd_nxt[HDR_BIT]  = hdr_r;
			end
			OFS_NODE_ID:
				rd_nxt[NODE_ID_W-1:0] = node_id_r;
			OFS_CLK_MHZ:
			begin
				rd_nxt[MHZ_W-1:0] = mhz_r;
				// out-of-range values refused even when locked
				nack_nxt = cfg_write && !mhz_ok; // RL8
			end
			OFS_LINK:
			begin
				rd_nxt[RX_ERR_BIT]    = rx_error_in;  // RL10
				rd_nxt[RX_CREDIT_BIT] = rx_credit_in; // RL11
				// local credit shown cleared right after greeting
				rd_nxt[TX_CREDIT_BIT] = tx_credit_in
					& ~send_greeting_strobe; // RL12 RL13
				rd_nxt[SYM_GAP_LSB +: GAP_W] = sym_gap_r;
				rd_nxt[TOK_GAP_LSB +: GAP_W] = tok_gap_r;
			end
			default:
				nack_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cfg_ack   <= 1'b0;
			cfg_nack  <= 1'b0;
			cfg_rdata <= '0;
		end
		else
		begin
			cfg_ack   <= cfg_req;
			cfg_nack  <= cfg_req & nack_nxt;
			cfg_rdata <= (cfg_req && !cfg_write) ? rd_nxt : '0;
		end
	end

	assign header_length_select  = hdr_r;
	assign node_identifier_field = node_id_r;
	assign clock_megahertz_field = mhz_r;
	assign symbol_gap_field      = sym_gap_r;
	assign token_gap_field       = tok_gap_r;
	assign update_lock           = lock_r;

endmodule : usb_node_config_regs

// [testbench/link_far_end.sv]
`timescale 1ns/1ns
module link_far_end (
	input  wire logic clk,                  // clock
	input  wire logic sys_rst,              // reset
	input  wire logic send_greeting_strobe, // greeting
	input  wire logic err_cmd,              // force bad token
	output logic      rx_error_in,          // error level
	output logic      rx_credit_in,         // credit given
	output logic      tx_credit_in          // credit held
);
	logic [2:0] wait_r;
	assign rx_error_in = err_cmd;
	always_ff @(posedge clk)
	begin
		if (sys_rst || send_greeting_strobe)
		begin
			rx_credit_in <= 1'b0;
			tx_credit_in <= 1'b0;
			wait_r <= sys_rst ? 3'h0 : 3'h4;
		end
		else if (wait_r != 3'h0)
		begin
			wait_r <= wait_r - 3'h1;
			rx_credit_in <= wait_r == 3'h1;
			tx_credit_in <= wait_r == 3'h1;
		end
	end
endmodule : link_far_end

// [testbench/node_cfg_checker.sv]
`timescale 1ns/1ns
module node_cfg_checker
	import node_cfg_pkg::*;
(
	input wire logic        clk, sys_rst, cfg_req, cfg_write, // bus
	input wire logic        cfg_ack, cfg_nack, update_lock,   // answers
	input wire logic        header_length_select,             // hdr
	input wire logic        send_greeting_strobe,             // greet
	input wire logic [7:0]  cfg_addr,                         // addr
	input wire logic [31:0] cfg_wdata,                        // data
	input wire logic [15:0] node_identifier_field,            // id
	input wire logic [6:0]  clock_megahertz_field             // mhz
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_wr(a);
		cfg_req && cfg_write && !update_lock && cfg_addr == a;
	endsequence
	a_ack_follows: assert property (cfg_req |=> cfg_ack)
		else $error("ack missing");
	a_ack_cause: assert property (cfg_ack |-> $past(cfg_req))
		else $error("stray ack");
	a_mhz_range: assert property (
		clock_megahertz_field inside {[MHZ_MIN:MHZ_MAX]})
		else $error("mhz out of range");
	a_bad_mhz: assert property (
		cfg_req && cfg_write && cfg_addr == OFS_CLK_MHZ
		&& (cfg_wdata < 5 || cfg_wdata > 100)
		|=> cfg_nack && $stable(clock_megahertz_field))
		else $error("bad mhz taken");
	a_lock_sticks: assert property (update_lock |=> update_lock)
		else $error("lock dropped");
	a_lock_freeze: assert property (
		update_lock |=> $stable(node_identifier_field))
		else $error("id changed while locked");
	a_greet_pulse: assert property (
		s_wr(OFS_LINK) ##0 cfg_wdata[GREET_BIT] |=> send_greeting_strobe)
		else $error("greeting missing");
	a_hdr_follows: assert property (
		s_wr(OFS_NODE_CONF) ##0 cfg_wdata[HDR_BIT] |=> header_length_select)
		else $error("hdr not set");
endmodule : node_cfg_checker
bind usb_node_config_regs node_cfg_checker chk_i (.clk, .sys_rst,
	.cfg_req, .cfg_write, .cfg_ack, .cfg_nack, .update_lock,
	.header_length_select, .send_greeting_strobe, .cfg_addr, .cfg_wdata,
	.node_identifier_field, .clock_megahertz_field);

// [testbench/tb.sv]
`timescale 1ns/1ns
module tb;
	import node_cfg_pkg::*;
	logic        clk, cfg_req, cfg_write, cfg_ack, cfg_nack, err_cmd, nk;
	logic        sys_rst = 1'b1;
	logic        rx_error_in, rx_credit_in, tx_credit_in, update_lock;
	logic        header_length_select, send_greeting_strobe, rx_reset_strobe;
	logic [7:0]  cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata, rd;
	logic [15:0] node_identifier_field;
	logic [6:0]  clock_megahertz_field;
	logic [10:0] symbol_gap_field, token_gap_field;
	int          miscompares = 0;
	int          checks = 0;
	usb_node_config_regs #(8'h3C, 8'h5A, 8'h69) dut (.clk, .sys_rst,
		.cfg_req, .cfg_write, .cfg_addr, .cfg_wdata, .cfg_ack, .cfg_nack,
		.cfg_rdata, .rx_error_in, .rx_credit_in, .tx_credit_in,
		.header_length_select, .node_identifier_field, .clock_megahertz_field,
		.send_greeting_strobe, .rx_reset_strobe, .symbol_gap_field,
		.token_gap_field, .update_lock);
	link_far_end far (.clk, .sys_rst, .send_greeting_strobe, .err_cmd,
		.rx_error_in, .rx_credit_in, .tx_credit_in);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	// answer is fixed one cycle after the request edge
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
		@(negedge clk);
		{cfg_req, cfg_write, cfg_addr, cfg_wdata} = {1'b1, w, a, d};
		@(negedge clk);
		cfg_req = 1'b0;
		chk("ack", cfg_ack, 1'b1);
		rd = cfg_rdata;
		nk = cfg_nack;
	endtask : xfer
	task automatic rst;
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
	endtask : rst
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic t_regs;
		logic [31:0] mt [5] = '{4, 5, 101, 100, 32'h8000_0032};
		xfer(1, OFS_IDENT, 32'h0);
		xfer(0, OFS_IDENT, 32'h0);
		chk("ident", rd, 32'h3C00_5A69);
		xfer(0, OFS_CLK_MHZ, 32'h0);
		chk("mhz", rd, 32'h19);
		xfer(0, OFS_LINK, 32'h0);
		chk("link", rd, 32'h801);
		xfer(1, OFS_NODE_ID, 32'hFFFF_ABCD);
		xfer(0, OFS_NODE_ID, 32'h0);
		chk("nid", rd, 32'hABCD);
		foreach (mt[i])
		begin
			xfer(1, OFS_CLK_MHZ, mt[i]);
			chk("nack", nk, mt[i] < 5 || mt[i] > 100);
		end
		chk("mhz", clock_megahertz_field, 7'h64);
		xfer(0, 8'h10, 32'h0);
		chk("unmapped", nk, 1'b1);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_link;
		xfer(1, OFS_LINK, 32'h01BF_F800);
		chk("greet", send_greeting_strobe, 1'b1);
		chk("rxrst", rx_reset_strobe, 1'b1);
		chk("gaps", {symbol_gap_field, token_gap_field}, 22'h3FF800);
		err_cmd = 1'b1;
		repeat (6) @(negedge clk);
		xfer(0, OFS_LINK, 32'h0);
		chk("status", rd, 32'h0E3F_F800);
		err_cmd = 1'b0;
		$display("t_link done");
	endtask : t_link
	task automatic t_lock;
		xfer(1, OFS_NODE_CONF, 32'h8000_0001);
		chk("lock", {header_length_select, update_lock}, 2'b11);
		xfer(1, OFS_NODE_ID, 32'h1234);
		xfer(1, OFS_LINK, 32'h5);
		xfer(0, OFS_NODE_ID, 32'h0);
		chk("nid", rd, 32'hABCD);
		chk("tok", token_gap_field, 11'h0);
		rst;
		chk("unlock", update_lock, 1'b0);
		$display("t_lock done");
	endtask : t_lock
	initial
	begin
		{cfg_req, cfg_write, cfg_addr, cfg_wdata, err_cmd} = '0;
		rst;
		t_regs;
		t_link;
		t_lock;
		tally_and_finish;
	end
	initial
	begin
		#500000;
		miscompares++;
		tally_and_finish;
	end
endmodule : tb
